// File: logic/dmacs_chan.sv
`timescale 1ns/10ps
module dmacs_chan
   import dmacs_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic wr_en,
   input wire logic [3:0] reg_idx,
   input wire logic [31:0] wdata,
   input wire logic rd_clear,
   input wire logic start,
   input wire logic stop,
   input wire logic fetch_ack,
   input wire logic [31:0] fetch_rdata,
   input wire logic item_ack,
   output logic active,
   output logic [31:0] rd_data,
   output logic irq,
   output logic fetch_req,
   output logic [31:0] fetch_addr,
   output logic fetch_port,
   output logic item_req,
   output logic [31:0] item_src,
   output logic [31:0] item_dst
);
   dmacs_state_t state;
   logic [2:0] irq_en, irq_stat, stat_set;
   logic [31:0] src, dst, next_addr, stash_addr, data_stride, src_stride, dst_stride;
   logic [4:0] next_ctrl, stash_ctrl;
   logic [DMACS_LEN_W-1:0] microblock_length, microblock_count, item_cnt, ub_cnt;
   logic [1:0] cfg;
   logic [2:0] word;
   logic in_list;
   wire fetch_done = (state == DMACS_FETCH) && fetch_ack;
   wire [2:0] last_word = 3'(next_ctrl[DMACS_VIEW_LSB +: 2]) + 3'h1;
   wire last_fetch = fetch_done && (word == last_word);
   wire [4:0] rd_ctrl = fetch_rdata[DMACS_DESC_CTRL_LSB +: 5];
   wire item_done = (state == DMACS_XFER) && item_ack;
   wire ub_end = item_done && (item_cnt + 1'b1 >= microblock_length);
   wire blk_end = ub_end && (ub_cnt + 1'b1 >= microblock_count);
   wire more_list = next_ctrl[DMACS_FETCH_EN];
   wire [31:0] src_step = (cfg[DMACS_SRC_INC] ? DMACS_ITEM_STEP + {16'h0000, data_stride[15:0]}
                          : 32'h0000_0000) + (ub_end ? src_stride : 32'h0000_0000);
   wire [31:0] dst_step = (cfg[DMACS_DST_INC] ? DMACS_ITEM_STEP + {16'h0000, data_stride[31:16]}
                          : 32'h0000_0000) + (ub_end ? dst_stride : 32'h0000_0000);

   assign active = (state != DMACS_IDLE);
   assign irq = |(irq_stat & irq_en);
   assign fetch_req = (state == DMACS_FETCH);
   assign fetch_addr = {next_addr[31:2], 2'b00} + {27'h0, word, 2'b00};
   assign fetch_port = next_addr[0];
   assign item_req = (state == DMACS_XFER);
   assign item_src = src;
   assign item_dst = dst;
   assign stat_set = {stop && active, blk_end && !more_list && in_list, blk_end};

   always_comb
   begin
      unique case (reg_idx)
         DMACS_C_IRQ_ENABLE: rd_data = {29'h0, irq_en};
         DMACS_C_IRQ_STATUS: rd_data = {29'h0, irq_stat};
         DMACS_C_SRC_ADDR: rd_data = src;
         DMACS_C_DST_ADDR: rd_data = dst;
         DMACS_C_NEXT_ADDR: rd_data = next_addr;
         DMACS_C_NEXT_CTRL: rd_data = {27'h0, next_ctrl};
         DMACS_C_UBLOCK: rd_data = {8'h00, microblock_length};
         DMACS_C_BLOCK: rd_data = {8'h00, microblock_count};
         DMACS_C_CONFIG: rd_data = {30'h0, cfg};
         DMACS_C_DATA_STRIDE: rd_data = data_stride;
         DMACS_C_SRC_STRIDE: rd_data = src_stride;
         DMACS_C_DST_STRIDE: rd_data = dst_stride;
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // Status flags: a new event wins over a clearing read in the same cycle.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq_stat <= 3'h0;
      else
         irq_stat <= (irq_stat & {3{!rd_clear}}) | stat_set;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= DMACS_IDLE;
         {irq_en, cfg, next_ctrl, stash_ctrl, word, in_list} <= '0;
         {src, dst, next_addr, stash_addr, data_stride, src_stride, dst_stride} <= '0;
         {microblock_length, microblock_count, item_cnt, ub_cnt} <= '0;
      end
      else if (stop && active)
         state <= DMACS_IDLE;
      else if (start && !active)
      begin
         item_cnt <= '0;
         ub_cnt <= '0;
         word <= DMACS_W_NEXT;
         in_list <= next_ctrl[DMACS_FETCH_EN];
         state <= next_ctrl[DMACS_FETCH_EN] ? DMACS_FETCH : DMACS_XFER;
      end
      else if (fetch_done)
      begin
         word <= word + 3'h1;
         unique case (word)
            DMACS_W_NEXT: stash_addr <= fetch_rdata;
            DMACS_W_UBLOCK:
            begin
               microblock_length <= fetch_rdata[DMACS_LEN_W-1:0];
               stash_ctrl <= rd_ctrl;
            end
            DMACS_W_SRC: if (next_ctrl[DMACS_SRC_UPD]) src <= fetch_rdata;
            DMACS_W_DST: if (next_ctrl[DMACS_DST_UPD]) dst <= fetch_rdata;
            default: microblock_count <= fetch_rdata[DMACS_LEN_W-1:0];
         endcase
         if (last_fetch)
         begin
            next_addr <= stash_addr;
            next_ctrl <= (word == DMACS_W_UBLOCK) ? rd_ctrl : stash_ctrl;
            item_cnt <= '0;
            ub_cnt <= '0;
            state <= DMACS_XFER;
         end
      end
      else if (item_done)
      begin
         src <= src + src_step;
         dst <= dst + dst_step;
         item_cnt <= ub_end ? '0 : item_cnt + 1'b1;
         ub_cnt <= ub_end ? ub_cnt + 1'b1 : ub_cnt;
         if (blk_end)
         begin
            word <= DMACS_W_NEXT;
            state <= (in_list && more_list) ? DMACS_FETCH : DMACS_IDLE;
         end
      end
      else if (wr_en)
      begin
         unique case (reg_idx)
            DMACS_C_IRQ_ENABLE: irq_en <= wdata[2:0];
            DMACS_C_SRC_ADDR: src <= wdata;
            DMACS_C_DST_ADDR: dst <= wdata;
            DMACS_C_NEXT_ADDR: next_addr <= wdata;
            DMACS_C_NEXT_CTRL: next_ctrl <= wdata[4:0];
            DMACS_C_UBLOCK: microblock_length <= wdata[DMACS_LEN_W-1:0];
            DMACS_C_BLOCK: microblock_count <= wdata[DMACS_LEN_W-1:0];
            DMACS_C_CONFIG: cfg <= wdata[1:0];
            DMACS_C_DATA_STRIDE: data_stride <= wdata;
            DMACS_C_SRC_STRIDE: src_stride <= wdata;
            DMACS_C_DST_STRIDE: dst_stride <= wdata;
            default: irq_en <= irq_en;
         endcase
      end
   end
endmodule // dmacs_chan

// File: logic/dmacs_pkg.sv
package dmacs_pkg;

   // Channel count default and byte step of one data item.
   localparam int unsigned DMACS_CHANNELS_DEF = 4;
   localparam logic [31:0] DMACS_ITEM_STEP = 32'h0000_0004;

   // Global register word indexes (byte offset = 4 * index).
   localparam logic [3:0] DMACS_G_ENABLE = 4'h0;
   localparam logic [3:0] DMACS_G_DISABLE = 4'h1;
   localparam logic [3:0] DMACS_G_STATUS = 4'h2;
   localparam logic [3:0] DMACS_G_IRQ_SET = 4'h3;
   localparam logic [3:0] DMACS_G_IRQ_CLR = 4'h4;
   localparam logic [3:0] DMACS_G_IRQ_MASK = 4'h5;

   // Channel windows are 64 bytes; channel n starts at byte 0x40 * (n + 1).
   localparam logic [5:0] DMACS_CH_WINDOW_FIRST = 6'h01;

   // Channel register word indexes inside a window.
   localparam logic [3:0] DMACS_C_IRQ_ENABLE = 4'h0;
   localparam logic [3:0] DMACS_C_IRQ_STATUS = 4'h1;
   localparam logic [3:0] DMACS_C_SRC_ADDR = 4'h2;
   localparam logic [3:0] DMACS_C_DST_ADDR = 4'h3;
   localparam logic [3:0] DMACS_C_NEXT_ADDR = 4'h4;
   localparam logic [3:0] DMACS_C_NEXT_CTRL = 4'h5;
   localparam logic [3:0] DMACS_C_UBLOCK = 4'h6;
   localparam logic [3:0] DMACS_C_BLOCK = 4'h7;
   localparam logic [3:0] DMACS_C_CONFIG = 4'h8;
   localparam logic [3:0] DMACS_C_DATA_STRIDE = 4'h9;
   localparam logic [3:0] DMACS_C_SRC_STRIDE = 4'hA;
   localparam logic [3:0] DMACS_C_DST_STRIDE = 4'hB;

   // Interrupt status and enable bit positions.
   localparam int unsigned DMACS_BLOCK_END = 0;
   localparam int unsigned DMACS_LIST_END = 1;
   localparam int unsigned DMACS_STOPPED = 2;

   // Next-descriptor control fields, also bits 28:24 of a descriptor microblock word.
   localparam int unsigned DMACS_FETCH_EN = 0;
   localparam int unsigned DMACS_SRC_UPD = 1;
   localparam int unsigned DMACS_DST_UPD = 2;
   localparam int unsigned DMACS_VIEW_LSB = 3;
   localparam int unsigned DMACS_DESC_CTRL_LSB = 24;
   localparam int unsigned DMACS_LEN_W = 24;

   // Config bits: source and destination address increment.
   localparam int unsigned DMACS_SRC_INC = 0;
   localparam int unsigned DMACS_DST_INC = 1;

   // Descriptor word positions: next pointer, microblock word, source, destination, block.
   localparam logic [2:0] DMACS_W_NEXT = 3'h0;
   localparam logic [2:0] DMACS_W_UBLOCK = 3'h1;
   localparam logic [2:0] DMACS_W_SRC = 3'h2;
   localparam logic [2:0] DMACS_W_DST = 3'h3;
   localparam logic [2:0] DMACS_W_BLOCK = 3'h4;

   typedef enum logic [1:0] {DMACS_IDLE, DMACS_FETCH, DMACS_XFER} dmacs_state_t;

endpackage

// File: logic/dmacs_top.sv
// Functional notes
// - Reading channel status clears its pending flags.
// - Microblock register holds items per microblock.
// - Block register holds microblocks per block.
// - Zero list and stride registers mean plain transfer.
// - Block interrupt needs channel and global enables.
// - Writing one to enable starts channel, sets active.
// - Completion sets block-end flag and raises interrupt.
// - Completion clears the active bit by hardware.
// - Each descriptor selects the next descriptor's view.
// - Fetching stops after descriptor with enable zero.
// - Next address register holds pointer and port.
// - Descriptors fetched only when fetch enable set.
// - Source update bit loads source per descriptor.
// - Destination update bit loads destination per descriptor.
// - View field sets first descriptor word count.
// - End-of-list interrupt enabled by its own bit.
// - Writing one to disable stops channel, clears active.
`timescale 1ns/10ps
module dmacs_top
   import dmacs_pkg::*;
#(
   parameter int unsigned CHANNELS = DMACS_CHANNELS_DEF
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic irq,
   output logic fetch_valid,
   output logic [31:0] fetch_addr,
   output logic fetch_port,
   input wire logic fetch_ready,
   input wire logic [31:0] fetch_rdata,
   output logic item_valid,
   output logic [31:0] item_src,
   output logic [31:0] item_dst,
   input wire logic item_ready
);
   import dmacs_pkg::*;

   localparam int unsigned SEL_W = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;

   if (CHANNELS < 1 || CHANNELS > 32)
   begin : g_bad_channels
      $error("Channel count must lie between 1 and 32.");
   end

   // Bus data phase state.
   logic dp_read, dp_write, rd_done;
   logic [9:0] dp_word;
   logic [CHANNELS-1:0] gie;

   // Per-channel wiring.
   logic [CHANNELS-1:0] ch_active, ch_irq, ch_wr, ch_clear, ch_start, ch_stop;
   logic [CHANNELS-1:0] ch_freq, ch_fport, ch_ireq, ch_fack, ch_iack;
   logic [31:0] ch_rd [CHANNELS];
   logic [31:0] ch_faddr [CHANNELS];
   logic [31:0] ch_isrc [CHANNELS];
   logic [31:0] ch_idst [CHANNELS];
   logic [SEL_W-1:0] fetch_sel, item_sel;

   // Address decode of the latched data phase.
   wire addr_take = hsel && htrans[1] && hready;
   wire [5:0] win = dp_word[9:4];
   wire [3:0] idx = dp_word[3:0];
   wire is_global = (win == 6'h00);
   wire [5:0] ch_num = win - DMACS_CH_WINDOW_FIRST;
   wire ch_hit = !is_global && (ch_num < 6'(CHANNELS));
   wire [SEL_W-1:0] ch_pick = ch_num[SEL_W-1:0];
   wire rd_now = dp_read && !rd_done;
   wire wr_now = dp_write && hreadyout;
   wire g_wr = wr_now && is_global;
   wire [CHANNELS-1:0] wmask = hwdata[CHANNELS-1:0];
   wire [31:0] gs_word = 32'(ch_active);
   wire [31:0] gim_word = 32'(gie);
   wire [31:0] g_rd = (idx == DMACS_G_STATUS) ? gs_word
                    : (idx == DMACS_G_IRQ_MASK) ? gim_word : 32'h0000_0000;
   wire [31:0] rd_word = is_global ? g_rd : (ch_hit ? ch_rd[ch_pick] : 32'h0000_0000);

   assign hreadyout = !rd_now;
   assign hresp = 1'b0;
   assign irq = |(ch_irq & gie);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_read <= 1'b0;
         dp_write <= 1'b0;
         rd_done <= 1'b0;
         dp_word <= 10'h000;
      end
      else if (hreadyout)
      begin
         dp_read <= addr_take && !hwrite;
         dp_write <= addr_take && hwrite;
         rd_done <= 1'b0;
         dp_word <= haddr[11:2];
      end
      else
         rd_done <= 1'b1;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (rd_now)
         hrdata <= rd_word;
   end

   // Global interrupt enable: set and clear registers act only on bits written as one.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         gie <= '0;
      else if (g_wr && idx == DMACS_G_IRQ_SET)
         gie <= gie | wmask;
      else if (g_wr && idx == DMACS_G_IRQ_CLR)
         gie <= gie & ~wmask;
   end

   assign ch_start = (g_wr && idx == DMACS_G_ENABLE) ? wmask : '0;
   assign ch_stop = (g_wr && idx == DMACS_G_DISABLE) ? wmask : '0;

   // Fixed priority, lowest channel first, for the shared fetch and item ports.
   always_comb
   begin
      fetch_sel = '0;
      item_sel = '0;
      for (int i = CHANNELS - 1; i >= 0; i--)
      begin
         if (ch_freq[i])
            fetch_sel = SEL_W'(i);
         if (ch_ireq[i])
            item_sel = SEL_W'(i);
      end
   end

   assign fetch_valid = |ch_freq;
   assign fetch_addr = ch_faddr[fetch_sel];
   assign fetch_port = ch_fport[fetch_sel];
   assign item_valid = |ch_ireq;
   assign item_src = ch_isrc[item_sel];
   assign item_dst = ch_idst[item_sel];

   for (genvar c = 0; c < CHANNELS; c++)
   begin : g_chan
      assign ch_wr[c] = wr_now && ch_hit && (ch_pick == SEL_W'(c));
      assign ch_clear[c] = rd_now && ch_hit && (ch_pick == SEL_W'(c))
                           && (idx == DMACS_C_IRQ_STATUS);
      assign ch_fack[c] = fetch_ready && ch_freq[c] && (fetch_sel == SEL_W'(c));
      assign ch_iack[c] = item_ready && ch_ireq[c] && (item_sel == SEL_W'(c));

      dmacs_chan u_chan (
         .hclk(hclk),
         .hresetn(hresetn),
         .wr_en(ch_wr[c]),
         .reg_idx(idx),
         .wdata(hwdata),
         .rd_clear(ch_clear[c]),
         .start(ch_start[c]),
         .stop(ch_stop[c]),
         .fetch_ack(ch_fack[c]),
         .fetch_rdata(fetch_rdata),
         .item_ack(ch_iack[c]),
         .active(ch_active[c]),
         .rd_data(ch_rd[c]),
         .irq(ch_irq[c]),
         .fetch_req(ch_freq[c]),
         .fetch_addr(ch_faddr[c]),
         .fetch_port(ch_fport[c]),
         .item_req(ch_ireq[c]),
         .item_src(ch_isrc[c]),
         .item_dst(ch_idst[c])
      );
   end
endmodule // dmacs_top

// File: testbench/dmacs_mem.sv
`timescale 1ns/10ps
module dmacs_mem
(
   input wire logic hclk,
   input wire logic slow,
   input wire logic fetch_valid,
   input wire logic [31:0] fetch_addr,
   input wire logic fetch_port,
   output logic fetch_ready,
   output logic [31:0] fetch_rdata,
   input wire logic item_valid,
   input wire logic [31:0] item_src,
   input wire logic [31:0] item_dst,
   output logic item_ready
);
   logic [31:0] desc [0:63];
   logic [31:0] slog [0:255];
   logic [31:0] dlog [0:255];
   logic tick = 1'b0;
   int fetches = 0;
   int items = 0;
   logic [31:0] first_addr;
   logic first_port;
   assign fetch_ready = !slow || tick;
   assign item_ready = !slow || tick;
   assign fetch_rdata = fetch_valid ? desc[fetch_addr[7:2]] : ~fetch_addr;
   always @(posedge hclk)
   begin
      tick <= ~tick;
      if (fetch_valid && fetch_ready)
      begin
         if (fetches == 0)
         begin
            first_addr <= fetch_addr;
            first_port <= fetch_port;
         end
         fetches <= fetches + 1;
      end
      if (item_valid && item_ready)
      begin
         slog[items[7:0]] <= item_src;
         dlog[items[7:0]] <= item_dst;
         items <= items + 1;
      end
   end
endmodule // dmacs_mem

// File: testbench/dmacs_top_monitor.sv
`timescale 1ns/10ps
module dmacs_top_monitor
   import dmacs_pkg::*;
#(
   parameter int unsigned CHANNELS = DMACS_CHANNELS_DEF
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic irq,
   input wire logic fetch_valid,
   input wire logic [31:0] fetch_addr,
   input wire logic fetch_ready,
   input wire logic item_valid,
   input wire logic item_ready
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic rd_take;
   logic wr_take;
   logic [3:0] age;
   assign rd_take = hsel && htrans[1] && hready && !hwrite;
   assign wr_take = hsel && htrans[1] && hready && hwrite;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         age <= 4'hF;
      else if (wr_take || (fetch_valid && fetch_ready) || (item_valid && item_ready))
         age <= 4'h0;
      else if (age != 4'hF)
         age <= age + 4'h1;
   end
   a_resp_okay: assert property (hresp == 1'b0) else $error("Response not OKAY.");
   a_write_no_wait: assert property (wr_take |=> hreadyout) else $error("Write waited.");
   a_read_one_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
      else $error("Read wait state wrong.");
   a_wait_after_read: assert property (!hreadyout |-> $past(rd_take))
      else $error("Wait state without read.");
   a_reset_quiet: assert property ($rose(hresetn) |-> !irq && !fetch_valid && !item_valid)
      else $error("Outputs busy after reset.");
   a_fetch_word_aligned: assert property (fetch_valid |-> fetch_addr[1:0] == 2'b00)
      else $error("Fetch address not aligned.");
   a_irq_has_cause: assert property ($rose(irq) |-> age <= 4'h3)
      else $error("Interrupt rose without cause.");
   a_fetch_has_cause: assert property ($rose(fetch_valid) |-> age <= 4'h3)
      else $error("Fetch began without cause.");
   a_item_has_cause: assert property ($rose(item_valid) |-> age <= 4'h3)
      else $error("Item began without cause.");
   c_read: cover property (rd_take);
   c_fetch: cover property (fetch_valid && fetch_ready);
   c_item: cover property (item_valid && item_ready);
   c_irq: cover property ($rose(irq));
endmodule // dmacs_top_monitor

bind dmacs_top dmacs_top_monitor #(.CHANNELS(CHANNELS)) u_mon (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
   .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .fetch_ready(fetch_ready),
   .item_valid(item_valid), .item_ready(item_ready));

// File: testbench/dmacs_top_tb.sv
`timescale 1ns/10ps
module dmacs_top_tb;
   import dmacs_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic slow = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, irq, fetch_valid, fetch_port, fetch_ready, item_valid, item_ready;
   logic [31:0] hrdata, fetch_addr, fetch_rdata, item_src, item_dst, seen;
   int err_count = 0;
   int checks_done = 0;
   int f0;
   int i0;
   always #12.5 hclk = ~hclk;
   dmacs_top #(.CHANNELS(4)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
      .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .fetch_port(fetch_port),
      .fetch_ready(fetch_ready), .fetch_rdata(fetch_rdata), .item_valid(item_valid),
      .item_src(item_src), .item_dst(item_dst), .item_ready(item_ready));
   dmacs_mem mem (.hclk(hclk), .slow(slow), .fetch_valid(fetch_valid),
      .fetch_addr(fetch_addr), .fetch_port(fetch_port), .fetch_ready(fetch_ready),
      .fetch_rdata(fetch_rdata), .item_valid(item_valid), .item_src(item_src),
      .item_dst(item_dst), .item_ready(item_ready));
   task report_and_stop;
      $display("Checks %0d, errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task give_up;
      err_count++;
      $display("BAD %0t wait ran out", $time);
      report_and_stop;
   endtask
   task check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task wait_ready;
      int n;
      n = 0;
      @(negedge hclk);
      while (hreadyout !== 1'b1 && n < 20)
      begin
         @(negedge hclk);
         n++;
      end
      seen = hrdata;
      if (n >= 20)
         give_up;
      @(posedge hclk);
   endtask
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      wait_ready;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready;
   endtask
   function automatic logic [31:0] ga(input logic [3:0] i);
      return {26'h0, i, 2'b00};
   endfunction
   function automatic logic [31:0] ca(input int c, input logic [3:0] i);
      return 32'h40 * (c + 1) + {26'h0, i, 2'b00};
   endfunction
   task wait_irq;
      int n;
      n = 0;
      @(negedge hclk);
      while (irq !== 1'b1 && n < 600)
      begin
         @(negedge hclk);
         n++;
      end
      if (n >= 600)
         give_up;
      @(posedge hclk);
   endtask
   task poll_idle(input int c);
      int n;
      n = 0;
      bus(1'b0, ga(DMACS_G_STATUS), 32'h0);
      while (seen[c] !== 1'b0 && n < 300)
      begin
         bus(1'b0, ga(DMACS_G_STATUS), 32'h0);
         n++;
      end
      if (n >= 300)
         give_up;
   endtask
   task setup(input int c, input logic [31:0] s, d, u, b, nc, ie);
      bus(1'b1, ca(c, DMACS_C_SRC_ADDR), s);
      bus(1'b1, ca(c, DMACS_C_DST_ADDR), d);
      bus(1'b1, ca(c, DMACS_C_UBLOCK), u);
      bus(1'b1, ca(c, DMACS_C_BLOCK), b);
      bus(1'b1, ca(c, DMACS_C_CONFIG), 32'h3);
      bus(1'b1, ca(c, DMACS_C_NEXT_CTRL), nc);
      bus(1'b1, ca(c, DMACS_C_DATA_STRIDE), 32'h0);
      bus(1'b1, ca(c, DMACS_C_SRC_STRIDE), 32'h0);
      bus(1'b1, ca(c, DMACS_C_DST_STRIDE), 32'h0);
      bus(1'b1, ca(c, DMACS_C_IRQ_ENABLE), ie);
      f0 = mem.fetches;
      i0 = mem.items;
   endtask
   task s_reset;
      bus(1'b1, ga(DMACS_G_ENABLE), 32'h10);
      bus(1'b0, ga(DMACS_G_STATUS), 32'h0);
      check(seen, 32'h0);
      bus(1'b0, ga(4'hF), 32'h0);
      check(seen, 32'h0);
   endtask
   task s_plain;
      slow <= 1'b1;
      bus(1'b0, ga(DMACS_G_STATUS), 32'h0);
      check(seen[0], 1'b0);
      bus(1'b0, ca(0, DMACS_C_IRQ_STATUS), 32'h0);
      setup(0, 32'h1000, 32'h2000, 32'h3, 32'h2, 32'h0, 32'h1);
      bus(1'b1, ga(DMACS_G_IRQ_SET), 32'h1);
      bus(1'b1, ga(DMACS_G_ENABLE), 32'h0);
      bus(1'b0, ga(DMACS_G_STATUS), 32'h0);
      check(seen[0], 1'b0);
      bus(1'b1, ga(DMACS_G_ENABLE), 32'h1);
      bus(1'b0, ga(DMACS_G_STATUS), 32'h0);
      check(seen[0], 1'b1);
      wait_irq;
      check(32'(mem.items - i0), 32'h6);
      check(mem.slog[i0 + 5], 32'h1014);
      check(32'(mem.fetches - f0), 32'h0);
      bus(1'b0, ca(0, DMACS_C_IRQ_STATUS), 32'h0);
      check(seen[0], 1'b1);
      bus(1'b0, ga(DMACS_G_STATUS), 32'h0);
      check(seen[0], 1'b0);
      check(irq, 1'b0);
   endtask
   task s_masked;
      slow <= 1'b0;
      setup(1, 32'h1100, 32'h2100, 32'h1, 32'h1, 32'h0, 32'h1);
      bus(1'b1, ca(1, DMACS_C_CONFIG), 32'h1);
      bus(1'b1, ca(1, DMACS_C_DATA_STRIDE), 32'h0010_0008);
      bus(1'b1, ca(1, DMACS_C_SRC_STRIDE), 32'h20);
      bus(1'b1, ga(DMACS_G_ENABLE), 32'h2);
      poll_idle(1);
      check(irq, 1'b0);
      check(mem.slog[i0], 32'h1100);
      check(mem.dlog[i0], 32'h2100);
      bus(1'b0, ca(1, DMACS_C_SRC_ADDR), 32'h0);
      check(seen, 32'h112C);
      bus(1'b0, ca(1, DMACS_C_DST_ADDR), 32'h0);
      check(seen, 32'h2100);
      bus(1'b0, ca(1, DMACS_C_IRQ_STATUS), 32'h0);
      check(seen[0], 1'b1);
      bus(1'b0, ca(1, DMACS_C_IRQ_STATUS), 32'h0);
      check(seen, 32'h0);
   endtask
   task s_list;
      setup(2, 32'h3000, 32'h4000, 32'h4, 32'h1, 32'hB, 32'h2);
      bus(1'b1, ca(2, DMACS_C_NEXT_ADDR), 32'h101);
      bus(1'b1, ga(DMACS_G_IRQ_SET), 32'h4);
      bus(1'b1, ga(DMACS_G_ENABLE), 32'h4);
      wait_irq;
      check(32'(mem.fetches - f0), 32'h7);
      check(mem.first_addr, 32'h100);
      check(mem.first_port, 1'b1);
      check(32'(mem.items - i0), 32'h3);
      check(mem.slog[i0], 32'h5000);
      check(mem.dlog[i0], 32'h4000);
      check(mem.slog[i0 + 2], 32'h6000);
      check(mem.dlog[i0 + 2], 32'h7000);
      bus(1'b0, ca(2, DMACS_C_IRQ_STATUS), 32'h0);
      check(seen[1], 1'b1);
   endtask
   task s_stop;
      slow <= 1'b1;
      setup(3, 32'h8000, 32'h9000, 32'hC8, 32'h1, 32'h0, 32'h4);
      bus(1'b1, ga(DMACS_G_ENABLE), 32'h8);
      bus(1'b1, ga(DMACS_G_DISABLE), 32'h0);
      bus(1'b0, ga(DMACS_G_STATUS), 32'h0);
      check(seen[3], 1'b1);
      bus(1'b1, ga(DMACS_G_DISABLE), 32'h8);
      poll_idle(3);
      check(mem.items - i0 < 200, 1'b1);
      bus(1'b0, ca(3, DMACS_C_IRQ_STATUS), 32'h0);
      check(seen[2], 1'b1);
   endtask
   initial
   begin
      mem.desc[0] = 32'h120;
      mem.desc[1] = 32'h1700_0002;
      mem.desc[2] = 32'h5000;
      mem.desc[8] = 32'h0;
      mem.desc[9] = 32'h1;
      mem.desc[10] = 32'h6000;
      mem.desc[11] = 32'h7000;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      s_reset;
      s_plain;
      s_masked;
      s_list;
      s_stop;
      report_and_stop;
   end
endmodule // dmacs_top_tb
